/* File: verilog/bper_map.svh */
`ifndef BPER_MAP_SVH
`define BPER_MAP_SVH

// Register indices; the byte address is four times the index.
`define BPER_IDX_RESP0 8'hdd
`define BPER_IDX_RESP1 8'he5
`define BPER_IDX_SEL0 8'h40
`define BPER_IDX_SEL1 8'h41
`define BPER_IDX_STAT 8'h42
`define BPER_IDX_MASK 8'h43
`define BPER_IDX_CNT0L 8'h44
`define BPER_IDX_CNT0H 8'h45
`define BPER_IDX_CNT1L 8'h46
`define BPER_IDX_CNT1H 8'h47

// Byte addresses within the low 12 bits of haddr.
`define BPER_ADDR(idx) {2'h0, idx, 2'h0}
`define BPER_ADDR_NONE 12'hfff

// Response configuration fields.
`define BPER_RESP_IRQ_HI 7
`define BPER_RESP_IRQ_LO 6
`define BPER_RESP_PIN_HI 5
`define BPER_RESP_PIN_LO 4
`define BPER_RESP_RESET 8'h00

// Event select fields.
`define BPER_SEL_CODE_HI 5
`define BPER_SEL_DATA_BIT 6
`define BPER_SEL_RESET 7'h00

// Interrupt mask and status resets.
`define BPER_MASK_RESET 2'h3
`define BPER_STAT_RESET 2'h0

`endif

/* File: verilog/bper_pkg.sv */
package bper_pkg;

   // Action taken by the pin and interrupt fields of a response register.
   typedef enum logic [1:0] {
      RESP_NEVER = 2'b00,
      RESP_RSVD = 2'b01,
      RESP_ON_EVENT = 2'b10,
      RESP_ON_OVF = 2'b11
   } bper_resp_mode_t;

   // Event selection codes; every other code is reserved.
   typedef enum logic [5:0] {
      EV_MEM_RD_CMD = 6'h0e,
      EV_MEM_WR_CMD = 6'h0f,
      EV_ANY_BUS = 6'h10,
      EV_ANY_MEM = 6'h11,
      EV_ANY_MEM_RD = 6'h12,
      EV_ANY_MEM_WR = 6'h13,
      EV_ANY_IO = 6'h14,
      EV_ANY_IO_MEM = 6'h15,
      EV_ANY_IO_MEM_RD = 6'h16,
      EV_ANY_IO_MEM_WR = 6'h17,
      EV_SNOOP_CLEAN = 6'h18,
      EV_SNOOP_MOD = 6'h19,
      EV_RETRY = 6'h1a,
      EV_DEFER = 6'h1b,
      EV_BLOCK_NEXT = 6'h1c,
      EV_PRIO_AGENT = 6'h1d,
      EV_LOCK = 6'h1e,
      EV_SIG_RSVD = 6'h1f,
      EV_BANK_IDLE = 6'h20,
      EV_ROW_PRECHARGE = 6'h21,
      EV_ADDR_WAIT = 6'h22,
      EV_PAGE_HIT = 6'h23
   } bper_event_code_t;

endpackage : bper_pkg

/* File: verilog/bper_top.sv */
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "bper_map.svh"

module bper_top #(
   parameter int CNT_W = 40
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic txn_valid,
   input wire logic txn_mem,
   input wire logic txn_io,
   input wire logic txn_write,
   input wire logic data_beat,
   input wire logic snoop_clean_signal,
   input wire logic snoop_modified_signal,
   input wire logic retry_signal,
   input wire logic defer_signal,
   input wire logic block_next_request_signal,
   input wire logic priority_agent_request_signal,
   input wire logic lock_signal,
   input wire logic bank_idle_event,
   input wire logic row_precharge_wait_event,
   input wire logic address_wait_event,
   input wire logic open_page_hit_event,
   output logic monitor_pin_0,
   output logic monitor_pin_1,
   output logic interrupt_request_pin_n
);

   localparam logic [11:0] ADDR_RESP [2] = '{`BPER_ADDR(`BPER_IDX_RESP0),
                                              `BPER_ADDR(`BPER_IDX_RESP1)};
   localparam logic [11:0] ADDR_SEL [2] = '{`BPER_ADDR(`BPER_IDX_SEL0),
                                             `BPER_ADDR(`BPER_IDX_SEL1)};
   localparam logic [11:0] ADDR_CNTL [2] = '{`BPER_ADDR(`BPER_IDX_CNT0L),
                                              `BPER_ADDR(`BPER_IDX_CNT1L)};
   localparam logic [11:0] ADDR_CNTH [2] = '{`BPER_ADDR(`BPER_IDX_CNT0H),
                                              `BPER_ADDR(`BPER_IDX_CNT1H)};
   localparam logic [11:0] ADDR_STAT = `BPER_ADDR(`BPER_IDX_STAT);
   localparam logic [11:0] ADDR_MASK = `BPER_ADDR(`BPER_IDX_MASK);

   logic [7:0] resp_reg [2];
   logic [6:0] sel_reg [2];
   logic [CNT_W-1:0] cnt_reg [2];
   logic [1:0] ovf_reg;
   logic [1:0] pin_reg;
   logic [1:0] stat_reg;
   logic [1:0] mask_reg;
   logic irq_n_reg;
   logic wr_pend_reg;
   logic [11:0] wr_addr_reg;
   logic [31:0] rdata_reg;
   logic [1:0] evt;
   logic [1:0] cause;
   logic [1:0] stat_clr;
   logic [31:0] rd_data;
   logic addr_phase;
   logic [11:0] addr_dec;

   // A transfer is taken when selected, ready and NONSEQ or SEQ (htrans[1] set); the upper
   // address bits must be zero or the access counts as unmapped.
   assign addr_phase = hsel && hready && htrans[1];
   assign addr_dec = (haddr[31:12] == 20'h0) ? haddr[11:0] : `BPER_ADDR_NONE;

   // Writes complete in the data phase, so the address phase is stored.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= `BPER_ADDR_NONE;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         wr_addr_reg <= addr_dec;
      end
   end

   // The slave never stalls and never errors, so both stay constant flops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Event decode: each counter matches its own selected code.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         logic m;
         logic txn_kind;
         m = 1'b0;
         txn_kind = 1'b0;
         case (sel_reg[i][`BPER_SEL_CODE_HI:0])
            bper_pkg::EV_MEM_RD_CMD: begin
               txn_kind = 1'b1;
               m = txn_valid && txn_mem && !txn_write;
            end
            bper_pkg::EV_MEM_WR_CMD: begin
               txn_kind = 1'b1;
               m = txn_valid && txn_mem && txn_write;
            end
            bper_pkg::EV_ANY_BUS: begin
               txn_kind = 1'b1;
               m = txn_valid;
            end
            bper_pkg::EV_ANY_MEM: begin
               txn_kind = 1'b1;
               m = txn_valid && txn_mem;
            end
            bper_pkg::EV_ANY_MEM_RD: begin
               txn_kind = 1'b1;
               m = txn_valid && txn_mem && !txn_write;
            end
            bper_pkg::EV_ANY_MEM_WR: begin
               txn_kind = 1'b1;
               m = txn_valid && txn_mem && txn_write;
            end
            bper_pkg::EV_ANY_IO: begin
               txn_kind = 1'b1;
               m = txn_valid && txn_io;
            end
            bper_pkg::EV_ANY_IO_MEM: begin
               txn_kind = 1'b1;
               m = txn_valid && (txn_io || txn_mem);
            end
            bper_pkg::EV_ANY_IO_MEM_RD: begin
               txn_kind = 1'b1;
               m = txn_valid && (txn_io || txn_mem) && !txn_write;
            end
            bper_pkg::EV_ANY_IO_MEM_WR: begin
               txn_kind = 1'b1;
               m = txn_valid && (txn_io || txn_mem) && txn_write;
            end
            bper_pkg::EV_SNOOP_CLEAN: m = snoop_clean_signal;
            bper_pkg::EV_SNOOP_MOD: m = snoop_modified_signal;
            bper_pkg::EV_RETRY: m = retry_signal;
            bper_pkg::EV_DEFER: m = defer_signal;
            bper_pkg::EV_BLOCK_NEXT: m = block_next_request_signal;
            bper_pkg::EV_PRIO_AGENT: m = priority_agent_request_signal;
            bper_pkg::EV_LOCK: m = lock_signal;
            bper_pkg::EV_BANK_IDLE: m = bank_idle_event;
            bper_pkg::EV_ROW_PRECHARGE: m = row_precharge_wait_event;
            bper_pkg::EV_ADDR_WAIT: m = address_wait_event;
            bper_pkg::EV_PAGE_HIT: m = open_page_hit_event;
            default: m = 1'b0;
         endcase
         // Data-cycle mode only gates transaction events; signal and memory
         // events keep counting occurrences and no qualifiers are applied.
         if (sel_reg[i][`BPER_SEL_DATA_BIT] && txn_kind) begin
            evt[i] = m && data_beat;
         end else begin
            evt[i] = m;
         end
      end
   end

   // Per-counter configuration, counting and response logic.
   for (genvar i = 0; i < 2; i++) begin : g_ctr
      logic wr_resp;
      logic wr_sel;
      logic wr_lo;
      logic wr_hi;
      bper_pkg::bper_resp_mode_t pin_mode;
      bper_pkg::bper_resp_mode_t irq_mode;

      assign wr_resp = wr_pend_reg && (wr_addr_reg == ADDR_RESP[i]);
      assign wr_sel = wr_pend_reg && (wr_addr_reg == ADDR_SEL[i]);
      assign wr_lo = wr_pend_reg && (wr_addr_reg == ADDR_CNTL[i]);
      assign wr_hi = wr_pend_reg && (wr_addr_reg == ADDR_CNTH[i]);
      // Only bits 7:4 are decoded; bits 3:0 are just storage.
      assign pin_mode = bper_pkg::bper_resp_mode_t'(
         resp_reg[i][`BPER_RESP_PIN_HI:`BPER_RESP_PIN_LO]);
      assign irq_mode = bper_pkg::bper_resp_mode_t'(
         resp_reg[i][`BPER_RESP_IRQ_HI:`BPER_RESP_IRQ_LO]);

      // Response and select registers, both cleared by reset.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            resp_reg[i] <= `BPER_RESP_RESET;
            sel_reg[i] <= `BPER_SEL_RESET;
         end else begin
            if (wr_resp) begin
               resp_reg[i] <= hwdata[7:0];
            end
            if (wr_sel) begin
               sel_reg[i] <= hwdata[6:0];
            end
         end
      end

      // Counter; a software write wins over a same-cycle count.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cnt_reg[i] <= '0;
            ovf_reg[i] <= 1'b0;
         end else begin
            ovf_reg[i] <= evt[i] && (&cnt_reg[i]) && !wr_lo && !wr_hi;
            if (wr_lo) begin
               cnt_reg[i][31:0] <= hwdata;
            end else if (wr_hi) begin
               cnt_reg[i][CNT_W-1:32] <= hwdata[CNT_W-33:0];
            end else if (evt[i]) begin
               cnt_reg[i] <= cnt_reg[i] + 1'b1;
            end
         end
      end

      // Each monitor pin follows only its own counter's event or overflow.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pin_reg[i] <= 1'b0;
         end else begin
            case (pin_mode)
               bper_pkg::RESP_ON_EVENT: pin_reg[i] <= evt[i];
               bper_pkg::RESP_ON_OVF: pin_reg[i] <= ovf_reg[i];
               default: pin_reg[i] <= 1'b0;
            endcase
         end
      end

      // Interrupt cause for this counter.
      always_comb begin
         case (irq_mode)
            bper_pkg::RESP_ON_EVENT: cause[i] = evt[i];
            bper_pkg::RESP_ON_OVF: cause[i] = ovf_reg[i];
            default: cause[i] = 1'b0;
         endcase
      end
   end

   assign stat_clr = (wr_pend_reg && (wr_addr_reg == ADDR_STAT)) ?
                     hwdata[1:0] : 2'h0;

   // Sticky status: writing one clears, a same-cycle cause wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_reg <= `BPER_STAT_RESET;
      end else begin
         stat_reg <= (stat_reg & ~stat_clr) | cause;
      end
   end

   // Interrupt mask, same layout as status.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_reg <= `BPER_MASK_RESET;
      end else if (wr_pend_reg && (wr_addr_reg == ADDR_MASK)) begin
         mask_reg <= hwdata[1:0];
      end
   end

   // Interrupt request is low while any unmasked status bit is set.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_n_reg <= 1'b1;
      end else begin
         irq_n_reg <= ~|(stat_reg & mask_reg);
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      rd_data = 32'h0;
      case (addr_dec)
         ADDR_RESP[0]: rd_data = {24'h0, resp_reg[0]};
         ADDR_RESP[1]: rd_data = {24'h0, resp_reg[1]};
         ADDR_SEL[0]: rd_data = {25'h0, sel_reg[0]};
         ADDR_SEL[1]: rd_data = {25'h0, sel_reg[1]};
         ADDR_STAT: rd_data = {30'h0, stat_reg};
         ADDR_MASK: rd_data = {30'h0, mask_reg};
         ADDR_CNTL[0]: rd_data = cnt_reg[0][31:0];
         ADDR_CNTL[1]: rd_data = cnt_reg[1][31:0];
         ADDR_CNTH[0]: rd_data = 32'(cnt_reg[0][CNT_W-1:32]);
         ADDR_CNTH[1]: rd_data = 32'(cnt_reg[1][CNT_W-1:32]);
         default: rd_data = 32'h0;
      endcase
   end

   // Read data is captured at the address phase and shown in the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 32'h0;
      end else if (addr_phase && !hwrite) begin
         rdata_reg <= rd_data;
      end
   end

   assign hrdata = rdata_reg;
   assign monitor_pin_0 = pin_reg[0];
   assign monitor_pin_1 = pin_reg[1];
   assign interrupt_request_pin_n = irq_n_reg;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Response register takes the written byte.
   resp_write_a: assert property (
      g_ctr[0].wr_resp |=> resp_reg[0] == $past(hwdata[7:0]))
      else $error("response register 0 did not take write data");

   // Event mode drives pin 0 one cycle after the event.
   pin_event_a: assert property (
      (g_ctr[0].pin_mode == bper_pkg::RESP_ON_EVENT) && evt[0]
      |=> monitor_pin_0)
      else $error("monitor pin 0 missed an event");

   // Pin 1 stays low unless counter 1 asks for it.
   pin_owner_a: assert property (
      !$past(resp_reg[1][`BPER_RESP_PIN_HI]) |-> !monitor_pin_1)
      else $error("monitor pin 1 driven without its own request");

   // Wrap gives a one-cycle overflow pulse and a zero counter.
   wrap_pulse_a: assert property (
      evt[0] && (&cnt_reg[0]) && !g_ctr[0].wr_lo && !g_ctr[0].wr_hi
      |=> ovf_reg[0] && (cnt_reg[0] == '0) ##1 !ovf_reg[0])
      else $error("counter 0 wrap did not pulse overflow once");

   // An interrupting event sets the counter's flag.
   flag_set_a: assert property (
      (g_ctr[1].irq_mode == bper_pkg::RESP_ON_EVENT) && evt[1]
      |=> stat_reg[1])
      else $error("status flag 1 not set by interrupt cause");

   // A flag holds until a clearing write.
   flag_hold_a: assert property (
      stat_reg[0] && !stat_clr[0] |=> stat_reg[0])
      else $error("status flag 0 dropped without a clear");

   // Unmasked status drives the interrupt low on the next cycle.
   irq_level_a: assert property (
      |(stat_reg & mask_reg) |=> !interrupt_request_pin_n)
      else $error("interrupt request not asserted");

   // Any-bus code counts each transaction.
   any_bus_a: assert property (
      (sel_reg[0] == {1'b0, bper_pkg::EV_ANY_BUS}) && txn_valid |-> evt[0])
      else $error("any bus transaction not counted");

   // I/O code counts I/O transactions.
   any_io_a: assert property (
      (sel_reg[0] == {1'b0, bper_pkg::EV_ANY_IO}) && txn_valid && txn_io
      |-> evt[0])
      else $error("I/O transaction not counted");

   // The reserved signal code never counts.
   sig_rsvd_a: assert property (
      sel_reg[0][5:0] == bper_pkg::EV_SIG_RSVD |-> !evt[0])
      else $error("reserved signal code produced an event");

   // Page hit code follows the page hit input.
   page_hit_a: assert property (
      (sel_reg[1][5:0] == bper_pkg::EV_PAGE_HIT) && open_page_hit_event
      |-> evt[1])
      else $error("page hit not counted");

   // Memory read command code counts memory reads.
   mem_rd_a: assert property (
      (sel_reg[0] == {1'b0, bper_pkg::EV_MEM_RD_CMD}) && txn_valid &&
      txn_mem && !txn_write |-> evt[0])
      else $error("memory read command not counted");

   pin_ovf_c: cover property (ovf_reg[0] ##1 monitor_pin_0);
   irq_c: cover property (!interrupt_request_pin_n ##[1:20] stat_clr[0]);
   sig_c: cover property (evt[1] && sel_reg[1][5:0] == bper_pkg::EV_LOCK);

endmodule : bper_top

/* File: sim/bper_agent.sv */
`timescale 1ns/1ps
// Stand-in for the bus agents and memory logic whose activity is monitored.
module bper_agent (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   output logic [15:0] drv_vec,
   output logic txn_valid,
   output logic txn_mem,
   output logic txn_io,
   output logic txn_write,
   output logic data_beat,
   output logic snoop_clean_signal,
   output logic snoop_modified_signal,
   output logic retry_signal,
   output logic defer_signal,
   output logic block_next_request_signal,
   output logic priority_agent_request_signal,
   output logic lock_signal,
   output logic bank_idle_event,
   output logic row_precharge_wait_event,
   output logic address_wait_event,
   output logic open_page_hit_event
);
   integer seed = 85;

   // Every line follows one shared vector, so the bench sees what the block saw.
   assign {open_page_hit_event, address_wait_event, row_precharge_wait_event,
      bank_idle_event, lock_signal, priority_agent_request_signal,
      block_next_request_signal, defer_signal, retry_signal,
      snoop_modified_signal, snoop_clean_signal, data_beat, txn_write,
      txn_io, txn_mem, txn_valid} = drv_vec;

   // Random activity while running; when idle only the qualifiers wander.
   // No agent, destination or length qualifier is offered at all.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drv_vec <= 16'h0000;
      end else if (run) begin
         drv_vec <= 16'($random(seed));
      end else begin
         drv_vec <= 16'($random(seed)) & 16'h001e;
      end
   end
endmodule : bper_agent

/* File: sim/bus_perf_event_response_tb.sv */
`timescale 1ns/1ps
`include "bper_map.svh"
module bus_perf_event_response_tb;
   localparam int CW = 34;
   localparam logic [11:0] A_SEL [2] = '{`BPER_ADDR(`BPER_IDX_SEL0),
      `BPER_ADDR(`BPER_IDX_SEL1)};
   localparam logic [11:0] A_RSP [2] = '{`BPER_ADDR(`BPER_IDX_RESP0),
      `BPER_ADDR(`BPER_IDX_RESP1)};
   localparam logic [11:0] A_CLO [2] = '{`BPER_ADDR(`BPER_IDX_CNT0L),
      `BPER_ADDR(`BPER_IDX_CNT1L)};
   localparam logic [11:0] A_CHI [2] = '{`BPER_ADDR(`BPER_IDX_CNT0H),
      `BPER_ADDR(`BPER_IDX_CNT1H)};
   localparam logic [11:0] A_STAT = `BPER_ADDR(`BPER_IDX_STAT);
   localparam logic [11:0] A_MASK = `BPER_ADDR(`BPER_IDX_MASK);
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic run = 1'b0;
   logic [15:0] drv_vec;
   logic txn_valid, txn_mem, txn_io, txn_write, data_beat;
   logic snoop_clean_signal, snoop_modified_signal, retry_signal;
   logic defer_signal, block_next_request_signal, lock_signal;
   logic priority_agent_request_signal, bank_idle_event;
   logic row_precharge_wait_event, address_wait_event, open_page_hit_event;
   logic [31:0] hrdata;
   logic hreadyout, hresp, monitor_pin_0, monitor_pin_1;
   logic interrupt_request_pin_n;
   wire logic hready;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [6:0] sel [2];
   logic [7:0] rsp [2];
   longint mc [2];
   int nev [2], nwr [2], npin [2];

   assign hready = hreadyout;

   bper_top #(.CNT_W(CW)) dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .txn_valid, .txn_mem, .txn_io,
      .txn_write, .data_beat, .snoop_clean_signal, .snoop_modified_signal,
      .retry_signal, .defer_signal, .block_next_request_signal,
      .priority_agent_request_signal, .lock_signal, .bank_idle_event,
      .row_precharge_wait_event, .address_wait_event, .open_page_hit_event,
      .monitor_pin_0, .monitor_pin_1, .interrupt_request_pin_n
   );

   bper_agent agent (
      .hclk, .hresetn, .run, .drv_vec, .txn_valid, .txn_mem, .txn_io,
      .txn_write, .data_beat, .snoop_clean_signal, .snoop_modified_signal,
      .retry_signal, .defer_signal, .block_next_request_signal,
      .priority_agent_request_signal, .lock_signal, .bank_idle_event,
      .row_precharge_wait_event, .address_wait_event, .open_page_hit_event
   );

   // The clock toggles every 2 ns, a period of 4 ns.
   always #2 hclk = ~hclk;

   // Reference decode of which selected event the sampled activity matches.
   function automatic logic hit(input logic [5:0] c, input logic [15:0] d);
      logic v, m, io, w;
      v = d[0];
      m = d[1];
      io = d[2];
      w = d[3];
      if (c >= 6'h18 && c <= 6'h1e) return d[c - 6'h13];
      if (c >= 6'h20 && c <= 6'h23) return d[c - 6'h14];
      case (c)
         6'h0e, 6'h12: return v & m & !w;
         6'h0f, 6'h13: return v & m & w;
         6'h10: return v;
         6'h11: return v & m;
         6'h14: return v & io;
         6'h15: return v & (m | io);
         6'h16: return v & (m | io) & !w;
         6'h17: return v & (m | io) & w;
         default: return 1'b0;
      endcase
   endfunction : hit

   // Expected effect count for a response mode: events, wraps or nothing.
   function automatic int pexp(input logic [1:0] m, input int k);
      return (m == 2'h2) ? nev[k] : (m == 2'h3) ? nwr[k] : 0;
   endfunction : pexp

   // The model counts events and wraps, and tallies the pins' high cycles.
   always @(posedge hclk) begin
      for (int k = 0; k < 2; k++) begin
         // Data-cycle mode gates only the transaction codes.
         if (hit(sel[k][5:0], drv_vec) && (!sel[k][6] ||
               sel[k][5:0] >= 6'h18 || drv_vec[4])) begin
            nev[k]++;
            mc[k] = mc[k] + 1;
            if (mc[k] == (longint'(1) << CW)) begin
               mc[k] = 0;
               nwr[k]++;
            end
         end
      end
      npin[0] += int'(monitor_pin_0);
      npin[1] += int'(monitor_pin_1);
   end

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what,
            got, exp);
      end
   endtask : chk

   // Waits for ready at a rising edge; a stuck bus ends the run.
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: bus wait ran out", $time);
         report_and_stop();
      end
   endtask : wait_rdy

   // One single word transfer: address phase, then data phase.
   task automatic ahb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      ahb(1'b1, a, d, rd);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
      input string what);
      logic [31:0] rd;
      ahb(1'b0, a, 32'h0, rd);
      chk(rd, exp, what);
      chk({31'h0, hresp}, 32'h0, "okay response");
   endtask : rdc

   // Programs both counters, runs traffic, then checks pins, counts, flags.
   task automatic run_case(input logic [6:0] c0, input logic [6:0] c1,
      input logic [7:0] r0, input logic [7:0] r1, input longint st);
      logic [1:0] se;
      sel[0] = c0;
      sel[1] = c1;
      rsp[0] = r0;
      rsp[1] = r1;
      for (int k = 0; k < 2; k++) begin
         wr(A_SEL[k], {25'h0, sel[k]});
         wr(A_RSP[k], {24'h0, rsp[k]});
         wr(A_CLO[k], st[31:0]);
         wr(A_CHI[k], {30'h0, st[33:32]});
      end
      wr(A_STAT, 32'h3);
      for (int k = 0; k < 2; k++) begin
         mc[k] = st;
         nev[k] = 0;
         nwr[k] = 0;
         npin[k] = 0;
      end
      run <= 1'b1;
      repeat (30) @(posedge hclk);
      run <= 1'b0;
      repeat (8) @(posedge hclk);
      se = 2'h0;
      for (int k = 0; k < 2; k++) begin
         chk(npin[k], pexp(rsp[k][5:4], k), "pin pulses");
         rdc(A_CLO[k], mc[k][31:0], "count");
         rdc(A_CHI[k], {30'h0, mc[k][33:32]}, "count high");
         rdc(A_RSP[k], {24'h0, rsp[k]}, "readback");
         se[k] = (pexp(rsp[k][7:6], k) != 0);
      end
      rdc(A_STAT, {30'h0, se}, "status");
      chk({31'h0, interrupt_request_pin_n}, {31'h0, ~|se}, "irq");
   endtask : run_case

   // Main sequence: reset, every code, every mode, then mask and clear.
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      chk({30'h0, monitor_pin_1, monitor_pin_0}, 32'h0, "pins");
      chk({31'h0, interrupt_request_pin_n}, 32'h1, "irq");
      rdc(A_RSP[0], 32'h0, "reset 0");
      rdc(A_RSP[1], 32'h0, "reset 1");
      // A set mask bit lets that status flag reach the interrupt pin.
      wr(A_MASK, 32'h3);
      for (int c = 0; c < 64; c++) begin
         run_case(7'(c), 7'(c ^ 7) | 7'h40, 8'haa, 8'h25, 0);
      end
      for (int m = 0; m < 4; m++) begin
         run_case(bper_pkg::EV_ANY_BUS, bper_pkg::EV_ANY_BUS,
            {2'(m), 2'(m), 4'h5}, {2'(3 - m), 2'(3 - m), 4'ha},
            (longint'(1) << CW) - 6);
      end
      run_case(bper_pkg::EV_ANY_BUS, 6'h3f, 8'h80, 8'h00, 0);
      wr(A_MASK, 32'h2);
      rdc(A_STAT, {31'h0, nev[0] != 0}, "sticky");
      chk({31'h0, interrupt_request_pin_n}, 32'h1, "masked irq");
      wr(A_MASK, 32'h3);
      rdc(A_STAT, {31'h0, nev[0] != 0}, "sticky");
      chk({31'h0, interrupt_request_pin_n}, {31'h0, nev[0] == 0}, "irq");
      wr(A_STAT, 32'h1);
      rdc(A_STAT, 32'h0, "cleared");
      chk({31'h0, interrupt_request_pin_n}, 32'h1, "irq cleared");
      wr(`BPER_ADDR_NONE, 32'hffff_ffff);
      rdc(`BPER_ADDR_NONE, 32'h0, "unmapped");
      report_and_stop();
   end
endmodule : bus_perf_event_response_tb
